// File: logic/resp_regs.svh
`ifndef RESP_REGS_SVH
`define RESP_REGS_SVH

`define RESP_ADDR_W          8
`define RESP_DATA_W          24
`define RESP_CTRL_ADDR       8'h00
`define RESP_STAT_ADDR       8'h01
`define RESP_CTRL_RESET      24'h000000
`define RESP_RSVD_MSB        23
`define RESP_RSVD_LSB        17
`define RESP_EVERY_CYCLE_BIT 16
`define RESP_SYNC_EN_BIT     15
`define RESP_BYPASS_BIT      14
`define RESP_OUT_SEL_BIT     13
`define RESP_CAP_SEL_BIT     12
`define RESP_GAIN_MSB        11
`define RESP_GAIN_LSB        8
`define RESP_GAIN_SAT_CODE   4'h9
`define RESP_GAIN_MAX        4'ha
`define RESP_STAT_PIN_BIT    0
`define RESP_STAT_RA_BIT     1
`define RESP_STAT_LL_BIT     2
`define RESP_STAT_LA_BIT     3
`define RESP_STAT_GAIN_LSB   4
`define RESP_STAT_GAIN_MSB   7
`define RESP_DAC_W           8
`define RESP_BURST_W         2
`define RESP_BURST_LAST      2'h3
`define RESP_CARRIER_CLKS    256
`define RESP_AGE_W           9
`define RESP_AGE_MAX         9'h1ff
`define RESP_SETTLE_AGE      9'h008
`define RESP_CARRIER_AGE     9'h100

`endif

// File: logic/resp_pkg.sv
`include "resp_regs.svh"

package resp_pkg;

  typedef struct packed {
    logic       every_cycle_waveform_sel;
    logic       carrier_sync_out_en;
    logic       onchip_amp_bypass;
    logic       drive_output_sel;
    logic       capacitor_source_sel;
    logic [3:0] resp_in_amp_gain;
  } ctrl_t;

  typedef struct packed {
    ctrl_t                      ctrl;
    logic [`RESP_DATA_W-1:0]    rdata;
    logic [3:0]                 gain_factor;
    logic                       pin_level;
    logic                       pin_oe_n;
    logic [`RESP_AGE_W-1:0]     mode_age;
  } bank_state_t;

  typedef struct packed {
    logic [`RESP_DAC_W-1:0]     phase;
    logic [`RESP_BURST_W-1:0]   burst;
    logic [`RESP_DAC_W-1:0]     code;
  } wave_state_t;

endpackage

// File: logic/resp_wave_gen.sv
`timescale 1ns/10ps
`include "resp_regs.svh"

module resp_wave_gen
  import resp_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_every_cycle,
  output logic [`RESP_DAC_W-1:0]      o_resp_drive_converter
);

  wave_state_t st_r;
  wave_state_t st_nxt;
  logic        active_nxt;

  // phase runs always so the burst spacing stays locked to the carrier
  always_comb begin
    st_nxt       = st_r;
    st_nxt.phase = st_r.phase + 8'h01;
    if (st_r.phase == 8'hff) begin
      st_nxt.burst = st_r.burst + 2'h1;
    end
    active_nxt  = i_every_cycle || (st_nxt.burst == 2'h0);
    st_nxt.code = active_nxt ? st_nxt.phase : 8'h00;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_resp_drive_converter = st_r.code;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_RUN_STEP: assert property (
    ($past(i_every_cycle) && $past(i_every_cycle, 2) && $past(i_nrst))
      |-> (st_r.code == $past(st_r.code) + 8'h01))
    else $error("waveform did not step every clock in every-cycle mode");

  AST_REST_ZERO: assert property (
    (!$past(i_every_cycle) && st_r.burst != 2'h0 && $past(i_nrst)) |-> (st_r.code == 8'h00))
    else $error("waveform not idle between bursts");

endmodule

// File: logic/respiration_control_bits.sv
`timescale 1ns/10ps
`include "resp_regs.svh"

// What this block does
// - sync bit drives converter msb onto pin three
// - sync period constant in both modes: 256 clocks in every-cycle mode, 1024 in every-N mode
// - bypass bit skips on-chip amplifier stage
// - output select picks left leg or left arm
// - external capacitors force right-arm drive only
// - capacitor bit picks internal or external capacitors
// - gain equals code plus one, saturating at ten
module respiration_control_bits
  import resp_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire logic [`RESP_ADDR_W-1:0] i_addr,
  input  wire logic [`RESP_DATA_W-1:0] i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [`RESP_DATA_W-1:0]      o_rdata,
  output logic                         o_general_pin_three,
  output logic                         o_general_pin_three_oe_n,
  output logic                         o_drive_out_right_arm,
  output logic                         o_drive_out_left_leg,
  output logic                         o_drive_out_left_arm,
  output logic                         o_onchip_amp_bypass,
  output logic                         o_capacitor_source_sel,
  output logic [3:0]                   o_gain_factor,
  output logic [`RESP_DAC_W-1:0]       o_resp_drive_converter
);

  bank_state_t            st_r;
  bank_state_t            st_nxt;
  logic [`RESP_DAC_W-1:0] dac_code;
  logic                   ra_en;
  logic                   ll_en;
  logic                   la_en;
  logic                   ctrl_wr;
  logic [3:0]             wgain;

  function automatic logic [3:0] sat_gain(input logic [3:0] code);
    // codes nine and above all land on the top gain
    if (code >= `RESP_GAIN_SAT_CODE) begin
      sat_gain = `RESP_GAIN_MAX;
    end else begin
      sat_gain = code + 4'h1;
    end
  endfunction

  function automatic ctrl_t unpack_ctrl(input logic [`RESP_DATA_W-1:0] d);
    unpack_ctrl.every_cycle_waveform_sel = d[`RESP_EVERY_CYCLE_BIT];
    unpack_ctrl.carrier_sync_out_en      = d[`RESP_SYNC_EN_BIT];
    unpack_ctrl.onchip_amp_bypass        = d[`RESP_BYPASS_BIT];
    unpack_ctrl.drive_output_sel         = d[`RESP_OUT_SEL_BIT];
    unpack_ctrl.capacitor_source_sel     = d[`RESP_CAP_SEL_BIT];
    unpack_ctrl.resp_in_amp_gain         = d[`RESP_GAIN_MSB:`RESP_GAIN_LSB];
  endfunction

  function automatic logic [`RESP_DATA_W-1:0] pack_ctrl(input ctrl_t c);
    pack_ctrl                                = '0;
    pack_ctrl[`RESP_EVERY_CYCLE_BIT]         = c.every_cycle_waveform_sel;
    pack_ctrl[`RESP_SYNC_EN_BIT]             = c.carrier_sync_out_en;
    pack_ctrl[`RESP_BYPASS_BIT]              = c.onchip_amp_bypass;
    pack_ctrl[`RESP_OUT_SEL_BIT]             = c.drive_output_sel;
    pack_ctrl[`RESP_CAP_SEL_BIT]             = c.capacitor_source_sel;
    pack_ctrl[`RESP_GAIN_MSB:`RESP_GAIN_LSB] = c.resp_in_amp_gain;
  endfunction

  assign ctrl_wr = i_wr && (i_addr == `RESP_CTRL_ADDR);
  assign wgain   = i_wdata[`RESP_GAIN_MSB:`RESP_GAIN_LSB];

  resp_wave_gen u_wave (
    .i_clk                  (i_clk),
    .i_nrst                 (i_nrst),
    .i_every_cycle          (st_r.ctrl.every_cycle_waveform_sel),
    .o_resp_drive_converter (dac_code)
  );

  // capacitor source overrides the output select
  assign ra_en = 1'b1;
  assign ll_en = !st_r.ctrl.capacitor_source_sel && !st_r.ctrl.drive_output_sel;
  assign la_en = !st_r.ctrl.capacitor_source_sel && st_r.ctrl.drive_output_sel;

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;
    if (ctrl_wr) begin
      // reserved and unused low bits are dropped here
      st_nxt.ctrl = unpack_ctrl(i_wdata);
    end
    if (ctrl_wr && (unpack_ctrl(i_wdata) != st_r.ctrl)) begin
      st_nxt.mode_age = '0;
    end else if (st_r.mode_age != `RESP_AGE_MAX) begin
      st_nxt.mode_age = st_r.mode_age + 9'h001;
    end
    if (i_rd) begin
      case (i_addr)
        `RESP_CTRL_ADDR: begin
          st_nxt.rdata = pack_ctrl(st_r.ctrl);
        end
        `RESP_STAT_ADDR: begin
          st_nxt.rdata[`RESP_STAT_PIN_BIT] = st_r.pin_level;
          st_nxt.rdata[`RESP_STAT_RA_BIT]  = ra_en;
          st_nxt.rdata[`RESP_STAT_LL_BIT]  = ll_en;
          st_nxt.rdata[`RESP_STAT_LA_BIT]  = la_en;
          st_nxt.rdata[`RESP_STAT_GAIN_MSB:`RESP_STAT_GAIN_LSB] = st_r.gain_factor;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    st_nxt.gain_factor = sat_gain(st_nxt.ctrl.resp_in_amp_gain);
    // pin is released, not held low, when sync is off
    st_nxt.pin_oe_n  = !st_nxt.ctrl.carrier_sync_out_en;
    st_nxt.pin_level = st_nxt.ctrl.carrier_sync_out_en && dac_code[`RESP_DAC_W-1];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r          <= '0;
      st_r.pin_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata                  = st_r.rdata;
  assign o_general_pin_three      = st_r.pin_level;
  assign o_general_pin_three_oe_n = st_r.pin_oe_n;
  assign o_drive_out_right_arm    = ra_en;
  assign o_drive_out_left_leg     = ll_en;
  assign o_drive_out_left_arm     = la_en;
  assign o_onchip_amp_bypass      = st_r.ctrl.onchip_amp_bypass;
  assign o_capacitor_source_sel   = st_r.ctrl.capacitor_source_sel;
  assign o_gain_factor            = st_r.gain_factor;
  assign o_resp_drive_converter   = dac_code;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_SYNC_PIN: assert property (
    (st_r.ctrl.carrier_sync_out_en && !ctrl_wr) |=> (o_general_pin_three == $past(dac_code[7])))
    else $error("pin three does not follow converter msb");

  AST_PIN_RELEASE: assert property (
    (!st_r.ctrl.carrier_sync_out_en && !ctrl_wr)
      |=> (o_general_pin_three_oe_n && !o_general_pin_three))
    else $error("pin three driven while sync disabled");

  // edges right after a control change are start-up edges, not periods
  AST_SYNC_PERIOD: assert property (
    ($rose(o_general_pin_three) && st_r.ctrl.every_cycle_waveform_sel
      && (st_r.mode_age >= `RESP_SETTLE_AGE))
      |-> ##256 ($rose(o_general_pin_three) || (st_r.mode_age < `RESP_CARRIER_AGE)))
    else $error("sync period not constant in every-cycle mode");

  AST_BYPASS: assert property (
    ctrl_wr |=> (o_onchip_amp_bypass == $past(i_wdata[14])))
    else $error("bypass did not follow write");

  AST_DRIVE_SEL: assert property (
    !o_capacitor_source_sel
      |-> (o_drive_out_right_arm && o_drive_out_left_leg != o_drive_out_left_arm))
    else $error("drive output selection wrong");

  AST_CAP_RA: assert property (
    (ctrl_wr && i_wdata[12]) |=> (o_drive_out_right_arm && !o_drive_out_left_leg
                                   && !o_drive_out_left_arm))
    else $error("external capacitors did not force right arm only");

  AST_CAP_SRC: assert property (
    ctrl_wr |=> (o_capacitor_source_sel == $past(i_wdata[12])))
    else $error("capacitor source did not follow write");

  AST_GAIN: assert property (
    ctrl_wr |=> (o_gain_factor == (($past(wgain) >= 4'h9) ? 4'ha : $past(wgain) + 4'h1)))
    else $error("gain factor wrong for code");

  AST_RSVD_READ: assert property (
    i_rd |=> (o_rdata[23:17] == 7'h00))
    else $error("reserved bits read nonzero");

  AST_READ_ONCE: assert property (
    !i_rd |=> (o_rdata == 24'h000000))
    else $error("read data outside answer cycle");

  AST_OUT_SEL_LL: assert property (
    (ctrl_wr && !i_wdata[`RESP_CAP_SEL_BIT])
      |=> (o_drive_out_left_leg == !$past(i_wdata[`RESP_OUT_SEL_BIT])))
    else $error("left leg drive does not follow output select");

  AST_OUT_SEL_LA: assert property (
    (ctrl_wr && !i_wdata[`RESP_CAP_SEL_BIT])
      |=> (o_drive_out_left_arm == $past(i_wdata[`RESP_OUT_SEL_BIT])))
    else $error("left arm drive does not follow output select");

  AST_SYNC_OE: assert property (
    ctrl_wr |=> (o_general_pin_three_oe_n == !$past(i_wdata[`RESP_SYNC_EN_BIT])))
    else $error("pin three enable does not follow sync bit");

  AST_CTRL_ECHO: assert property (
    (ctrl_wr ##1 !i_wr ##1 (i_rd && (i_addr == `RESP_CTRL_ADDR)))
      |=> ((o_rdata[`RESP_EVERY_CYCLE_BIT:`RESP_GAIN_LSB]
            == $past(i_wdata[`RESP_EVERY_CYCLE_BIT:`RESP_GAIN_LSB], 3))
           && (o_rdata[`RESP_GAIN_LSB-1:0] == 8'h00)))
    else $error("control read does not return written fields");

  AST_STAT_GAIN: assert property (
    (i_rd && (i_addr == `RESP_STAT_ADDR))
      |=> (o_rdata[`RESP_STAT_GAIN_MSB:`RESP_STAT_GAIN_LSB] == $past(o_gain_factor)))
    else $error("status gain field differs from gain output");

  AST_CTRL_HOLD: assert property (
    !ctrl_wr |=> ($stable(o_onchip_amp_bypass) && $stable(o_capacitor_source_sel)))
    else $error("control output moved without a control write");

  COV_SYNC_TOGGLE: cover property (
    st_r.ctrl.carrier_sync_out_en ##1 $rose(o_general_pin_three));
  COV_CAP_EXT: cover property (ctrl_wr && i_wdata[12]);
  COV_GAIN_SAT: cover property (o_gain_factor == 4'ha);
  COV_CTRL_READ: cover property (
    (i_rd && (i_addr == `RESP_CTRL_ADDR)) ##1 (o_rdata != 24'h000000));
  COV_REST_BURST: cover property (
    (!st_r.ctrl.every_cycle_waveform_sel && st_r.ctrl.carrier_sync_out_en) ##1 (dac_code == 8'h00));

endmodule

// File: test/tb_respiration_control_bits.sv
`timescale 1ns/10ps
`include "resp_regs.svh"

module tb_respiration_control_bits;
  import resp_pkg::*;

  logic                    i_clk;
  logic                    i_nrst;
  logic [`RESP_ADDR_W-1:0] i_addr;
  logic [`RESP_DATA_W-1:0] i_wdata;
  logic                    i_wr;
  logic                    i_rd;
  logic [`RESP_DATA_W-1:0] o_rdata;
  logic                    pin;
  logic                    pin_oe_n;
  logic                    ra;
  logic                    ll;
  logic                    la;
  logic                    bypass;
  logic                    cap;
  logic [3:0]              gain;
  logic [`RESP_DAC_W-1:0]  conv;
  logic [`RESP_DAC_W-1:0]  prev;
  logic [23:0]             d;
  logic [23:0]             m;
  logic [23:0]             q;
  int                      num_errors;
  int                      check_count;
  int                      zeros;
  int                      gf;

  respiration_control_bits i_dut (
    .i_clk                    (i_clk),
    .i_nrst                   (i_nrst),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (o_rdata),
    .o_general_pin_three      (pin),
    .o_general_pin_three_oe_n (pin_oe_n),
    .o_drive_out_right_arm    (ra),
    .o_drive_out_left_leg     (ll),
    .o_drive_out_left_arm     (la),
    .o_onchip_amp_bypass      (bypass),
    .o_capacitor_source_sel   (cap),
    .o_gain_factor            (gain),
    .o_resp_drive_converter   (conv)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // strobes last one cycle; the next access may start at the following edge
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask

  initial begin
    #(25 * 10000);
    num_errors++;
    finish_test();
  end

  initial begin
    i_nrst = 1'b0;
    i_addr = 8'h00;
    i_wdata = 24'h000000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'h8556));
    repeat (5) @(posedge i_clk);
    chk("rst_oe_n", {23'h0, pin_oe_n}, 24'h1);
    chk("rst_ra", {23'h0, ra}, 24'h1);
    i_nrst <= 1'b1;
    rd(8'h00, q);
    chk("ctrl_reset", q, 24'h000000);
    chk("gain_reset", {20'h0, gain}, 24'h1);
    // sweep every gain code with random other bits, reserved bits kept at zero
    for (int g = 0; g < 16; g++) begin
      d = 24'($urandom);
      d[`RESP_RSVD_MSB:`RESP_RSVD_LSB] = 7'h00;
      d[11:8] = 4'(g);
      m = d & 24'h01ff00;
      gf = (g + 1 > 10) ? 10 : g + 1;
      wr(8'h00, d);
      @(negedge i_clk);
      chk("gain", {20'h0, gain}, 24'(gf));
      chk("bypass", {23'h0, bypass}, {23'h0, d[14]});
      chk("cap", {23'h0, cap}, {23'h0, d[12]});
      chk("ll", {23'h0, ll}, {23'h0, ~d[12] & ~d[13]});
      chk("la", {23'h0, la}, {23'h0, ~d[12] & d[13]});
      chk("ra", {23'h0, ra}, 24'h1);
      chk("oe_n", {23'h0, pin_oe_n}, {23'h0, ~d[15]});
      rd(8'h00, q);
      chk("ctrl_read", q, m);
      rd(8'h01, q);
      // pin level follows the free-running converter msb, so it is left out of the status compare
      chk("status", q & 24'hfffffe, {16'h0, 4'(gf), ~d[12] & d[13], ~d[12] & ~d[13], 1'b1, 1'b0});
    end
    // refused places: unmapped write, status write, unmapped read
    wr(8'h05, 24'hffffff);
    wr(8'h01, 24'hffffff);
    rd(8'h00, q);
    chk("ctrl_kept", q, m);
    rd(8'h7f, q);
    chk("unmapped", q, 24'h000000);
    @(negedge i_clk);
    chk("rdata_one_cycle", o_rdata, 24'h000000);
    // every-cycle waveform: sawtooth steps each clock, pin follows its msb
    wr(8'h00, 24'h018000);
    // the first code after the write still comes from the old mode
    repeat (2) @(negedge i_clk);
    prev = conv;
    repeat (300) begin
      @(negedge i_clk);
      chk("pin_msb", {23'h0, pin}, {23'h0, prev[7]});
      chk("code_step", {16'h0, conv}, {16'h0, prev + 8'h01});
      prev = conv;
    end
    // every-N mode: most carrier periods stay silent
    wr(8'h00, 24'h008000);
    @(negedge i_clk);
    prev = conv;
    zeros = 0;
    repeat (1024) begin
      @(negedge i_clk);
      chk("pin_msb_n", {23'h0, pin}, {23'h0, prev[7]});
      if (conv === 8'h00) begin
        zeros++;
      end
      prev = conv;
    end
    chk("silent_share", {23'h0, zeros >= 768}, 24'h1);
    wr(8'h00, 24'h000000);
    @(negedge i_clk);
    chk("pin_off_oe_n", {23'h0, pin_oe_n}, 24'h1);
    chk("pin_off", {23'h0, pin}, 24'h0);
    finish_test();
  end
endmodule
